// ==== rtl/supply_protection_panel_control.sv ====
// Protection, setting limits, panel lock and start-up control of a
// programmable DC supply with an APB register port.
// Assumes debounced panel inputs from another clock, async comparators.
//
// Function
// - Over-voltage trips output, code, blink, status
// - One protection press adjusts level, holds display
// - Over-voltage level floor five percent above setpoint
// - Output-on or power cycle clears over-voltage trip
// - Shut-off cycle clears over-voltage and over-current trips in auto-restart only
// - Under-voltage limit only blocks low programming
// - Two protection presses adjust under-voltage limit
// - Under-voltage cap five percent below, floor zero
// - Over-current button arms protection, lights indicator
// - Armed constant-current entry trips output
// - Button after trip disarms; output-on restores
// - Over-temperature trips output, code, blink, status
// - Safe-start latches over-temperature until output-on
// - Auto-restart over-temperature recovers when cleared
// - Brief mains loss sets power-fail, restart by mode
// - Held limit button cycles lock codes, release selects
// - Locked panel ignores knobs, over-current button and short output-on press
// - Locked panel still previews protection and settings
// - Panel and remote locks are independent
// - Output-on press toggles output; off drives zero
// - Held output-on cycles start modes every three seconds
// - Auto-restart saves and restores the listed settings
`timescale 1ns/100ps
`include "supply_params.svh"

module supply_protection_panel_control #(
    parameter int  VW        = 16,
    parameter int  STEP      = 16,
    parameter int  HOLD_CYC  = `HOLD_CYC,
    parameter int  CYCLE_CYC = `CYCLE_CYC,
    parameter int  LONG_CYC  = `LONG_CYC
) (
    // Clock and reset
    input  wire logic               pclk,
    input  wire logic               presetn,
    // APB slave
    input  wire logic               psel,
    input  wire logic               penable,
    input  wire logic               pwrite,
    input  wire logic [11:0]        paddr,
    input  wire logic [31:0]        pwdata,
    output logic      [31:0]        prdata,
    output logic                    pready,
    output logic                    pslverr,
    // Front panel
    input  wire supply_pkg::buttons_t buttons,
    input  wire supply_pkg::knobs_t   knobs,
    output supply_pkg::disp_t       display_code,
    output logic                    prot_blink,
    output logic                    ocp_led,
    output logic                    out_on_led,
    // Analog side
    input  wire supply_pkg::analog_t  analog,
    input  wire logic               power_up,
    output logic                    output_enable,
    output logic      [VW-1:0]      vprog,
    output logic      [VW-1:0]      iprog
);
    import supply_pkg::*;

    // ==========================================================
    // Input synchronisers
    // ==========================================================
    localparam int NS = 15;
    logic [NS-1:0] s1_reg, s2_reg, s3_reg;
    wire  [NS-1:0] raw = {buttons, knobs, analog, power_up};
    // Two stages; the third only feeds edge detection
    always_ff @(posedge pclk or negedge presetn)
    begin
        if (!presetn)
        begin
            s1_reg <= '0;
            s2_reg <= '0;
            s3_reg <= '0;
        end
        else
        begin
            s1_reg <= raw;
            s2_reg <= s1_reg;
            s3_reg <= s2_reg;
        end
    end
    buttons_t b, b_d;
    knobs_t   k, k_d;
    analog_t  a, a_d;
    logic     pwr_up, pwr_up_d;
    assign {b, k, a, pwr_up}       = s2_reg;
    assign {b_d, k_d, a_d, pwr_up_d} = s3_reg;

    // Press and release edges
    wire prot_press = b.protection_setting_button
                      && !b_d.protection_setting_button;
    wire lim_rel    = !b.limit_button && b_d.limit_button;
    wire ocp_press  = b.overcurrent_button && !b_d.overcurrent_button;
    wire on_rel     = !b.out_on_button && b_d.out_on_button;
    wire vstep      = k.volt_step && !k_d.volt_step;
    wire istep      = k.curr_step && !k_d.curr_step;
    wire cc_rise    = a.cc_mode && !a_d.cc_mode;
    wire so_off     = a.shutoff && !a_d.shutoff;
    wire so_on      = !a.shutoff && a_d.shutoff;
    wire pwr_rise   = pwr_up && !pwr_up_d;

    // ==========================================================
    // Margin arithmetic
    // ==========================================================
    function automatic logic [VW-1:0] margin(input logic [VW-1:0] v);
        logic [VW+7:0] p;
        p = {8'h00, v} * (VW+8)'(`MARGIN_NUM);
        margin = VW'(p >> `MARGIN_SHIFT);
    endfunction

    function automatic logic [VW-1:0] sat_add(input logic [VW-1:0] x,
                                             input logic [VW-1:0] y);
        logic [VW:0] s;
        s = {1'b0, x} + {1'b0, y};
        sat_add = s[VW] ? '1 : s[VW-1:0];
    endfunction

    // ==========================================================
    // State
    // ==========================================================
    typedef enum logic [2:0] {
        ADJ_NONE, ADJ_OVP, ADJ_UVL, ADJ_LIMIT, ADJ_LOCKMSG
    } adj_t;
    adj_t          adj_reg;
    logic [VW-1:0] vset_reg, iset_reg, ovp_reg, uvl_reg;
    logic          out_on_reg, ocp_arm_reg, auto_reg, lock_reg;
    logic          rlock_reg;
    logic [3:0]    status_reg;
    logic          ov_trip_reg, oc_trip_reg, ot_trip_reg;
    logic [31:0]   hold_cnt_reg, press_cnt_reg;
    logic          long_on_reg, long_lim_reg, cyc_sel_reg;
    logic [VW*4+4:0] saved_reg;

    wire panel_locked = lock_reg;
    wire any_trip     = ov_trip_reg | oc_trip_reg | ot_trip_reg;
    wire [VW-1:0] ovp_floor = sat_add(vset_reg, margin(vset_reg));
    wire [VW-1:0] uvl_cap = (vset_reg > margin(vset_reg))
                            ? vset_reg - margin(vset_reg) : '0;
    wire [VW-1:0] ovp_min = sat_add(vset_reg, margin(vset_reg));

    // APB decode
    wire wr = psel && penable && pwrite;
    wire rd_sel = psel && !penable;
    wire w_ctrl = wr && paddr == `OFS_CTRL;
    wire w_stat = wr && paddr == `OFS_STATUS;
    wire w_vset = wr && paddr == `OFS_VSET;
    wire w_iset = wr && paddr == `OFS_ISET;
    wire w_ovp  = wr && paddr == `OFS_OVP;
    wire w_uvl  = wr && paddr == `OFS_UVL;
    wire w_rem  = wr && paddr == `OFS_REMOTE;
    wire clr_cmd = w_ctrl && pwdata[`CTRL_CLR];
    wire on_short = on_rel && !long_on_reg && !panel_locked;

    // ==========================================================
    // Display adjust mode and hold timer
    // ==========================================================
    always_ff @(posedge pclk or negedge presetn)
    begin
        if (!presetn)
        begin
            adj_reg      <= ADJ_NONE;
            hold_cnt_reg <= '0;
        end
        else if (prot_press)
        begin
            adj_reg      <= (adj_reg == ADJ_OVP) ? ADJ_UVL : ADJ_OVP;
            hold_cnt_reg <= 32'(HOLD_CYC);
        end
        else if (lim_rel && !long_lim_reg)
        begin
            adj_reg      <= ADJ_LIMIT;
            hold_cnt_reg <= 32'(HOLD_CYC);
        end
        else if (panel_locked && (vstep || istep || ocp_press || on_rel))
        begin
            adj_reg      <= ADJ_LOCKMSG;
            hold_cnt_reg <= 32'(HOLD_CYC);
        end
        else if (vstep && adj_reg != ADJ_NONE)
            hold_cnt_reg <= 32'(HOLD_CYC);
        else if (hold_cnt_reg != 0)
        begin
            hold_cnt_reg <= hold_cnt_reg - 32'd1;
            if (hold_cnt_reg == 32'd1)
                adj_reg <= ADJ_NONE;
        end
    end

    // ==========================================================
    // Settings: knobs and APB; limits enforced
    // ==========================================================
    always_ff @(posedge pclk or negedge presetn)
    begin
        if (!presetn)
        begin
            vset_reg <= '0;
            iset_reg <= '0;
            ovp_reg  <= `OVP_RESET;
            uvl_reg  <= `UVL_RESET;
        end
        else if (pwr_rise && auto_reg)
            {vset_reg, iset_reg, ovp_reg, uvl_reg} <= saved_reg[VW*4+4:5];
        else if (pwr_rise)
        begin
            vset_reg <= '0;
            iset_reg <= '0;
            ovp_reg  <= `OVP_RESET;
            uvl_reg  <= `UVL_RESET;
        end
        else if (vstep && !panel_locked)
        begin
            case (adj_reg)
                ADJ_OVP:
                    if (k.volt_up)
                        ovp_reg <= sat_add(ovp_reg, VW'(STEP));
                    else if (ovp_reg >= ovp_min + VW'(STEP))
                        ovp_reg <= ovp_reg - VW'(STEP);
                ADJ_UVL:
                    if (k.volt_up)
                    begin
                        if (uvl_reg + VW'(STEP) <= uvl_cap)
                            uvl_reg <= uvl_reg + VW'(STEP);
                    end
                    else
                        uvl_reg <= (uvl_reg > VW'(STEP))
                                   ? uvl_reg - VW'(STEP) : '0;
                default:
                    if (k.volt_up)
                        vset_reg <= sat_add(vset_reg, VW'(STEP));
                    else if (vset_reg >= uvl_reg + VW'(STEP))
                        vset_reg <= vset_reg - VW'(STEP);
            endcase
        end
        else if (istep && !panel_locked)
            iset_reg <= k.curr_up ? sat_add(iset_reg, VW'(STEP))
                      : (iset_reg > VW'(STEP) ? iset_reg - VW'(STEP) : '0);
        else if (w_vset && pwdata[VW-1:0] >= uvl_reg)
            vset_reg <= pwdata[VW-1:0];
        else if (w_iset)
            iset_reg <= pwdata[VW-1:0];
        else if (w_ovp && pwdata[VW-1:0] >= ovp_floor)
            ovp_reg <= pwdata[VW-1:0];
        else if (w_uvl && pwdata[VW-1:0] <= uvl_cap)
            uvl_reg <= pwdata[VW-1:0];
    end

    // ==========================================================
    // Long-press timers for output-on and limit buttons
    // ==========================================================
    always_ff @(posedge pclk or negedge presetn)
    begin
        if (!presetn)
        begin
            press_cnt_reg <= '0;
            long_on_reg   <= 1'b0;
            long_lim_reg  <= 1'b0;
            cyc_sel_reg   <= 1'b0;
        end
        else if (!b.out_on_button && !b.limit_button)
        begin
            press_cnt_reg <= '0;
            long_on_reg   <= 1'b0;
            long_lim_reg  <= 1'b0;
        end
        else if (!long_on_reg && !long_lim_reg)
        begin
            press_cnt_reg <= press_cnt_reg + 32'd1;
            if (press_cnt_reg == 32'(LONG_CYC))
            begin
                press_cnt_reg <= '0;
                long_on_reg   <= b.out_on_button;
                long_lim_reg  <= b.limit_button;
                cyc_sel_reg   <= b.out_on_button ? auto_reg : !lock_reg;
            end
        end
        else if (press_cnt_reg == 32'(CYCLE_CYC) - 32'd1)
        begin
            press_cnt_reg <= '0;
            cyc_sel_reg   <= !cyc_sel_reg;
        end
        else
            press_cnt_reg <= press_cnt_reg + 32'd1;
    end

    // ==========================================================
    // Mode, lock and arming
    // ==========================================================
    always_ff @(posedge pclk or negedge presetn)
    begin
        if (!presetn)
        begin
            auto_reg    <= 1'b0;
            lock_reg    <= 1'b0;
            rlock_reg   <= 1'b0;
            ocp_arm_reg <= 1'b0;
        end
        else
        begin
            if (on_rel && long_on_reg)
                auto_reg <= cyc_sel_reg;
            else if (w_ctrl)
                auto_reg <= pwdata[`CTRL_AUTO];
            if (lim_rel && long_lim_reg)
                lock_reg <= !cyc_sel_reg;
            else if (pwr_rise)
                lock_reg <= auto_reg && saved_reg[2];
            if (w_rem)
                rlock_reg <= pwdata[0];
            if (ocp_press && !panel_locked)
                ocp_arm_reg <= !ocp_arm_reg;
            else if (pwr_rise)
                ocp_arm_reg <= auto_reg && saved_reg[3];
            else if (w_ctrl)
                ocp_arm_reg <= pwdata[`CTRL_OCP_ARM];
        end
    end

    // ==========================================================
    // Trips, output enable and status
    // ==========================================================
    always_ff @(posedge pclk or negedge presetn)
    begin
        if (!presetn)
        begin
            out_on_reg  <= 1'b0;
            ov_trip_reg <= 1'b0;
            oc_trip_reg <= 1'b0;
            ot_trip_reg <= 1'b0;
            status_reg  <= '0;
        end
        else
        begin
            // Clearing first; a live condition re-trips below
            if (on_short && any_trip || clr_cmd)
            begin
                ov_trip_reg <= 1'b0;
                oc_trip_reg <= 1'b0;
                ot_trip_reg <= 1'b0;
                out_on_reg  <= 1'b1;
            end
            else if (on_short)
                out_on_reg <= !out_on_reg;
            else if (so_on && auto_reg)
            begin
                ov_trip_reg <= 1'b0;
                oc_trip_reg <= 1'b0;
                out_on_reg  <= 1'b1;
            end
            else if (pwr_rise)
            begin
                ov_trip_reg <= 1'b0;
                oc_trip_reg <= 1'b0;
                out_on_reg  <= auto_reg && saved_reg[0];
            end
            else if (w_ctrl)
                out_on_reg <= pwdata[`CTRL_OUT_ON];
            if (so_off)
                out_on_reg <= 1'b0;
            if (ot_trip_reg && auto_reg && !a.ot_sense)
                ot_trip_reg <= 1'b0;
            if (a.ov_sense && out_on_reg)
            begin
                ov_trip_reg <= 1'b1;
                out_on_reg  <= 1'b0;
            end
            if (cc_rise && ocp_arm_reg && out_on_reg)
            begin
                oc_trip_reg <= 1'b1;
                out_on_reg  <= 1'b0;
            end
            if (a.ot_sense)
                ot_trip_reg <= 1'b1;
            // Set wins over a software clear of the same bit
            status_reg <= (w_stat ? status_reg & ~pwdata[3:0] : status_reg)
                | {a.ac_brief_loss, a.ot_sense,
                   cc_rise && ocp_arm_reg && out_on_reg,
                   a.ov_sense && out_on_reg};
        end
    end

    // Snapshot of restorable settings, taken when power_up falls
    always_ff @(posedge pclk or negedge presetn)
    begin
        if (!presetn)
            saved_reg <= '0;
        else if (!pwr_up && pwr_up_d)
            saved_reg <= {vset_reg, iset_reg, ovp_reg, uvl_reg,
                          auto_reg, ocp_arm_reg, lock_reg, 1'b0,
                          out_on_reg};
    end

    // ==========================================================
    // Outputs
    // ==========================================================
    wire live = out_on_reg && !any_trip;
    always_ff @(posedge pclk or negedge presetn)
    begin
        if (!presetn)
        begin
            output_enable <= 1'b0;
            vprog         <= '0;
            iprog         <= '0;
            display_code  <= DISP_OFF;
            prot_blink    <= 1'b0;
            ocp_led       <= 1'b0;
            out_on_led    <= 1'b0;
        end
        else
        begin
            output_enable <= live;
            vprog         <= live ? vset_reg : '0;
            iprog         <= live ? iset_reg : '0;
            prot_blink    <= any_trip;
            ocp_led       <= ocp_arm_reg;
            out_on_led    <= live;
            if (long_on_reg)
                display_code <= cyc_sel_reg ? DISP_AUTO : DISP_SAFE;
            else if (long_lim_reg)
                display_code <= cyc_sel_reg ? DISP_UNLOCKED : DISP_LOCKED;
            else if (adj_reg == ADJ_OVP)
                display_code <= DISP_OVP_LEVEL;
            else if (adj_reg == ADJ_UVL)
                display_code <= DISP_UVL_LEVEL;
            else if (adj_reg == ADJ_LOCKMSG)
                display_code <= DISP_LOCKED;
            else if (adj_reg == ADJ_LIMIT)
                display_code <= DISP_LIMIT;
            else if (ov_trip_reg)
                display_code <= DISP_OVP_TRIP;
            else if (oc_trip_reg && ocp_arm_reg)
                display_code <= DISP_OCP_TRIP;
            else if (ot_trip_reg)
                display_code <= DISP_OTP_TRIP;
            else
                display_code <= live ? DISP_NORMAL : DISP_OFF;
        end
    end

    // APB read data, registered in setup; zero wait states
    always_ff @(posedge pclk or negedge presetn)
    begin
        if (!presetn)
            prdata <= '0;
        else if (rd_sel)
            case (paddr)
                `OFS_CTRL:   prdata <= {28'h0000000, lock_reg, auto_reg,
                                        ocp_arm_reg, out_on_reg};
                `OFS_STATUS: prdata <= {28'h0000000, status_reg};
                `OFS_VSET:   prdata <= 32'(vset_reg);
                `OFS_ISET:   prdata <= 32'(iset_reg);
                `OFS_OVP:    prdata <= 32'(ovp_reg);
                `OFS_UVL:    prdata <= 32'(uvl_reg);
                `OFS_REMOTE: prdata <= {31'h00000000, rlock_reg};
                default:     prdata <= '0;
            endcase
    end
    assign pready  = 1'b1;
    assign pslverr = psel && penable && paddr > `OFS_REMOTE;
endmodule

// ==== rtl/supply_params.svh ====
// Constants for the supply protection and panel control block.
// Assumes inclusion from the testbench and the design file only.
`ifndef SUPPLY_PARAMS_SVH
`define SUPPLY_PARAMS_SVH
// Register byte offsets (APB, one word each)
`define OFS_CTRL        12'h000
`define OFS_STATUS      12'h004
`define OFS_VSET        12'h008
`define OFS_ISET        12'h00c
`define OFS_OVP         12'h010
`define OFS_UVL         12'h014
`define OFS_REMOTE      12'h018
`define OFS_SAVED       12'h01c
// Control register bits
`define CTRL_OUT_ON     0
`define CTRL_OCP_ARM    1
`define CTRL_AUTO       2
`define CTRL_PANEL_LOCK 3
`define CTRL_CLR        4
// Status register bits
`define ST_OV           0
`define ST_OC           1
`define ST_OT           2
`define ST_PF           3
// Margin in 1/256 steps: 13/256 is about 5 percent
`define MARGIN_NUM      13
`define MARGIN_SHIFT    8
// Reset values
`define OVP_RESET       16'hffff
`define UVL_RESET       16'h0000
// Timing figures
`define CLK_MHZ         250
`define HOLD_S          5
`define CYCLE_S         3
`define LONG_MS         1000
`define HOLD_CYC        (`HOLD_S * `CLK_MHZ * 1000000)
`define CYCLE_CYC       (`CYCLE_S * `CLK_MHZ * 1000000)
`define LONG_CYC        (`LONG_MS * `CLK_MHZ * 1000)
`endif

// ==== rtl/supply_pkg.sv ====
// Types shared by the supply protection and panel control block.
// Assumes the params header defines the constants.
package supply_pkg;
    typedef enum logic [3:0] {
        DISP_NORMAL, DISP_OFF, DISP_OVP_TRIP, DISP_OCP_TRIP,
        DISP_OTP_TRIP, DISP_OVP_LEVEL, DISP_UVL_LEVEL,
        DISP_LOCKED, DISP_UNLOCKED, DISP_SAFE, DISP_AUTO,
        DISP_LIMIT
    } disp_t;
    typedef struct packed {
        logic protection_setting_button;
        logic limit_button;
        logic overcurrent_button;
        logic out_on_button;
        logic fine_unused;
    } buttons_t;
    typedef struct packed {
        logic       volt_step;
        logic       volt_up;
        logic       curr_step;
        logic       curr_up;
    } knobs_t;
    typedef struct packed {
        logic ov_sense;
        logic cc_mode;
        logic ot_sense;
        logic ac_brief_loss;
        logic shutoff;
    } analog_t;
endpackage

// ==== tb/supply_chk_asserts.sv ====
// Port checker for the supply protection and panel block.
// Assumes a bind onto the top module; trips come from idle.
`timescale 1ns/100ps
// ==========
// Checker
module supply_chk
import supply_pkg::*;
#(
    parameter int VW = 16
)
(
    // Clock, reset, bus
    input wire logic                 pclk,
    input wire logic                 presetn,
    input wire logic                 psel,
    input wire logic                 penable,
    input wire logic [11:0]          paddr,
    input wire logic [31:0]          prdata,
    input wire logic                 pready,
    input wire logic                 pslverr,
    // Panel and analog side
    input wire supply_pkg::analog_t  analog,
    input wire supply_pkg::disp_t    display_code,
    input wire logic                 prot_blink,
    input wire logic                 ocp_led,
    input wire logic                 output_enable,
    input wire logic [VW-1:0]        vprog,
    input wire logic [VW-1:0]        iprog
);
    default clocking @(posedge pclk); endclocking
    default disable iff (!presetn);

    // Bus answers at once; unmapped words refused
    a_ready_high: assert property (pready)
        else $error("pready low");
    a_err_map: assert property (psel && penable |->
        pslverr == (paddr > 12'h018)) else $error("pslverr wrong");
    a_rdata_hold: assert property (!psel && $past(!psel) |->
        $stable(prdata)) else $error("prdata moved");
    // Disabled output drives zero
    a_off_zero: assert property (
        !output_enable |-> vprog == '0 && iprog == '0)
        else $error("prog not zero");
    // Trips shut the output and show their code
    a_ov_trip: assert property (
        $rose(analog.ov_sense) && output_enable |-> ##[1:8]
        !output_enable && display_code == DISP_OVP_TRIP)
        else $error("no ov trip");
    a_ov_blink: assert property (
        $rose(analog.ov_sense) && output_enable |-> ##[1:8] prot_blink)
        else $error("no blink");
    a_oc_trip: assert property (
        ocp_led && $rose(analog.cc_mode) && output_enable |-> ##[1:8]
        !output_enable && display_code == DISP_OCP_TRIP)
        else $error("no oc trip");
    a_ot_trip: assert property (
        $rose(analog.ot_sense) && output_enable |-> ##[1:8]
        !output_enable && display_code == DISP_OTP_TRIP)
        else $error("no ot trip");
    c_ov: cover property (display_code == DISP_OVP_TRIP);
    c_oc: cover property (display_code == DISP_OCP_TRIP);
    c_ot: cover property (display_code == DISP_OTP_TRIP);
endmodule

bind supply_protection_panel_control supply_chk #(.VW(VW)) u_chk (.*);

// ==== tb/panel_model.sv ====
// Front panel model: buttons and voltage knob.
// Assumes calls made just after a rising clock edge.
`timescale 1ns/100ps
// ==========
// Panel
module panel_model
(
    // Clock
    input wire logic             pclk,
    // Controls
    output supply_pkg::buttons_t buttons,
    output supply_pkg::knobs_t   knobs
);
    import supply_pkg::*;
    // Idle panel at time zero
    initial
    begin
        buttons = '0;
        knobs = '0;
    end
    // Hold a button set; short holds stay under the long threshold
    task automatic press(input buttons_t m, input int n);
        buttons <= m;
        repeat (n) @(posedge pclk);
        buttons <= '0;
    endtask
    // One voltage detent, rising step edge
    task automatic detent(input logic up);
        knobs <= {1'b1, up, 2'h0};
        repeat (4) @(posedge pclk);
        knobs <= 4'h0;
    endtask
endmodule

// ==== tb/testbench.sv ====
// Self-checking bench: APB tasks plus panel and analog stimulus.
// Assumes short hold, cycle and long-press counts.
`timescale 1ns/100ps
`include "supply_params.svh"
module testbench;
    import supply_pkg::*;
    // ==========
    // Signals
    logic        pclk, presetn, psel, penable, pwrite, power_up;
    logic        pready, pslverr, err, prot_blink, ocp_led, out_on_led;
    logic        output_enable;
    logic [11:0] paddr;
    logic [31:0] pwdata, prdata, q;
    logic [15:0] vprog, iprog;
    buttons_t    buttons;
    knobs_t      knobs;
    analog_t     analog;
    disp_t       display_code;
    int          n_mismatch, samples_checked;
    localparam buttons_t B_OUT = 5'h02, B_OCP = 5'h04, B_PROT = 5'h10;

    supply_protection_panel_control #(.HOLD_CYC(50), .CYCLE_CYC(40),
        .LONG_CYC(20)) dut (.*);
    panel_model u_panel (.*);

    // Clock and watchdog
    initial
    begin
        pclk = 1'b0;
        forever #2 pclk = ~pclk;
    end
    initial
    begin
        repeat (20000) @(posedge pclk);
        n_mismatch++;
        report_and_stop();
    end
    // ==========
    // Tasks
    task automatic chk(input string nm, input logic [31:0] got, exp);
        samples_checked++;
        if (got !== exp)
        begin
            n_mismatch++;
            $display("wrong value %s exp %h seen %h", nm, exp, got);
        end
    endtask
    task automatic report_and_stop;
        $display("mismatches %0d checks %0d", n_mismatch, samples_checked);
        if (n_mismatch == 0 && samples_checked > 0)
            $display("No errors found");
        else
            $display("Errors were found");
        $finish;
    endtask
    // Setup, then access until pready; release after that edge
    task automatic apb(input logic w, input logic [11:0] a,
                       input logic [31:0] d);
        int n;
        psel <= 1'b1;
        pwrite <= w;
        paddr <= a;
        pwdata <= d;
        @(posedge pclk);
        penable <= 1'b1;
        n = 0;
        do
        begin
            @(posedge pclk);
            n++;
        end
        while (pready !== 1'b1 && n < 20);
        if (pready !== 1'b1)
        begin
            n_mismatch++;
            report_and_stop();
        end
        q = prdata;
        err = pslverr;
        psel <= 1'b0;
        penable <= 1'b0;
        @(posedge pclk);
    endtask
    task automatic rd(input logic [11:0] a, input logic [31:0] e);
        apb(1'b0, a, 32'h0);
        chk("read", q, e);
    endtask
    // Short press, then let the synchronisers catch up
    task automatic tap(input buttons_t m);
        u_panel.press(m, 6);
        repeat (14) @(posedge pclk);
    endtask
    // ==========
    // Sequence
    initial
    begin
        {presetn, psel, penable, pwrite, paddr, pwdata} = '0;
        power_up = 1'b1;
        analog = '0;
        n_mismatch = 0;
        samples_checked = 0;
        repeat (3) @(posedge pclk);
        presetn <= 1'b1;
        @(posedge pclk);
        chk("disp", display_code, DISP_OFF);
        rd(`OFS_STATUS, 32'h0);
        apb(1'b0, 12'h020, 32'h0);
        chk("slverr", err, 1'b1);
        apb(1'b1, `OFS_VSET, 32'h100);
        apb(1'b1, `OFS_ISET, 32'h80);
        apb(1'b1, `OFS_OVP, 32'h10c);
        rd(`OFS_OVP, 32'hffff);
        apb(1'b1, `OFS_OVP, 32'h10d);
        rd(`OFS_OVP, 32'h10d);
        apb(1'b1, `OFS_UVL, 32'hf4);
        rd(`OFS_UVL, 32'h0);
        apb(1'b1, `OFS_UVL, 32'hf3);
        rd(`OFS_UVL, 32'hf3);
        apb(1'b1, `OFS_VSET, 32'hf0);
        rd(`OFS_VSET, 32'h100);
        tap(B_OUT);
        chk("on", {output_enable, out_on_led}, 2'b11);
        chk("prog", {vprog, iprog}, 32'h0100_0080);
        tap(B_PROT);
        chk("disp", display_code, DISP_OVP_LEVEL);
        u_panel.detent(1'b0);
        rd(`OFS_OVP, 32'h10d);
        u_panel.detent(1'b1);
        rd(`OFS_OVP, 32'h11d);
        repeat (80) @(posedge pclk);
        chk("disp", display_code, DISP_NORMAL);
        // Over-voltage trip, retrip while present, then recover
        analog.ov_sense <= 1'b1;
        tap(B_OUT);
        chk("ov", {output_enable, prot_blink}, 2'b01);
        rd(`OFS_STATUS, 32'h1);
        analog.ov_sense <= 1'b0;
        tap(B_OUT);
        chk("en", output_enable, 1'b1);
        tap(B_OCP);
        chk("led", ocp_led, 1'b1);
        analog.cc_mode <= 1'b1;
        repeat (8) @(posedge pclk);
        chk("disp", display_code, DISP_OCP_TRIP);
        tap(B_OCP);
        chk("oc", {output_enable, ocp_led}, 2'b00);
        chk("disp", display_code, DISP_OFF);
        tap(B_OUT);
        chk("en", output_enable, 1'b1);
        rd(`OFS_STATUS, 32'h3);
        analog.cc_mode <= 1'b0;
        analog.ot_sense <= 1'b1;
        tap(B_OCP);
        rd(`OFS_STATUS, 32'h7);
        analog.ot_sense <= 1'b0;
        tap(B_OCP);
        chk("disp", display_code, DISP_OTP_TRIP);
        tap(B_OUT);
        chk("en", output_enable, 1'b1);
        analog.ac_brief_loss <= 1'b1;
        tap(B_OCP);
        rd(`OFS_STATUS, 32'hf);
        // Auto-restart: over-temperature recovers by itself
        apb(1'b1, `OFS_CTRL, 32'h5);
        analog.ot_sense <= 1'b1;
        tap(B_OCP);
        chk("ot", output_enable, 1'b0);
        analog.ot_sense <= 1'b0;
        tap(B_OCP);
        chk("auto", output_enable, 1'b1);
        apb(1'b1, `OFS_REMOTE, 32'h1);
        rd(`OFS_REMOTE, 32'h1);
        rd(`OFS_CTRL, 32'h5);
        report_and_stop();
    end
endmodule
